// ==== design/dfs_pkg.sv ====
// Constants, codes and carrier types for the dual queue flag block.
// Assumes both port clocks arrive as plain inputs sampled by ref_clk.
// Summary of operation
// [R1] Port A empty clears after port B write
// [R2] Narrow port B write counts at last piece
// [R3] Port A full clears after port B read
// [R4] Narrow port B read counts at last piece
// [R5] Port B full clears after port A read
// [R6] Port B full sets on last piece write
// [R7] Port B almost-empty clears after port A write
// [R8] Port B almost-empty sets on last piece read
// [R9] Port A almost-empty clears after port B write
// [R10] Port A almost-empty skew from last piece write
// [R11] Port A almost-full clears after port B read
// [R12] Port B almost-full clears after A read, last piece
// [R13] Both size selects low pick long word
// [R14] A-to-B queue access select codes
// [R15] B-to-A queue access select codes
// [R16] Parity generation select low disables it (no parity logic here; parity_gen_en is unused)
// [R17] Port B empty sets on last piece read
// [R18] Both size selects high pick mailbox
// [R19] Full flags set on writer's own edge
// [R20] Empty flags set on reader's own edge
package dfs_pkg;
    // ==========================================
    // Widths and depth
    localparam int DATA_W = 36;
    localparam int DEPTH = 16;
    localparam int LVL_W = 5;
    localparam int WORD_W = 18;
    localparam int BYTE_W = 9;
    localparam logic [LVL_W-1:0] LVL_DEPTH = 5'h10;
    localparam logic [DATA_W-1:0] DATA_RESET = 36'h0_0000_0000;

    // ==========================================
    // Port B size codes, {hi, lo}
    localparam logic [1:0] SIZ_LONG = 2'h0;
    localparam logic [1:0] SIZ_WORD = 2'h1;
    localparam logic [1:0] SIZ_BYTE = 2'h2;
    localparam logic [1:0] SIZ_MAIL = 2'h3;
    localparam logic [1:0] LAST_LONG = 2'h0;
    localparam logic [1:0] LAST_WORD = 2'h1;
    localparam logic [1:0] LAST_BYTE = 2'h3;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic select_n;
        logic direction;
        logic mailbox_sel;
        logic parity_gen_en;
    } dfs_port_ctl_t;

    typedef struct packed {
        logic empty;
        logic almost_empty;
        logic full;
        logic almost_full;
    } dfs_flags_t;
endpackage : dfs_pkg

// ==== design/dfs_queue.sv ====
// Parameterised storage queue with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ns
module dfs_queue #(
    parameter int WIDTH = 36,
    parameter int QDEPTH = 16,
    parameter int PTR_W = $clog2(QDEPTH),
    parameter int CNT_W = $clog2(QDEPTH + 1)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Fill side
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    // Drain side
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data,
    // Occupancy
    output logic [CNT_W-1:0] level
);
    // ==========================================
    // Storage and pointers
    logic [WIDTH-1:0] mem_reg [QDEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] level_reg;
    wire logic push = wr_valid && wr_ready;
    wire logic pop = rd_valid && rd_ready;

    assign wr_ready = (level_reg != CNT_W'(QDEPTH));
    assign rd_valid = (level_reg != '0);
    // Array is flip-flops, so the head word is read straight from a register
    assign rd_data = mem_reg[rd_ptr_reg];
    assign level = level_reg;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_W'(QDEPTH - 1)) ? '0 : PTR_W'(wr_ptr_reg + 1'b1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_W'(QDEPTH - 1)) ? '0 : PTR_W'(rd_ptr_reg + 1'b1);
            end
            level_reg <= CNT_W'(level_reg + CNT_W'(push) - CNT_W'(pop));
        end
    end
endmodule : dfs_queue

// ==== design/dfs_flag_sync.sv ====
// Two opposing queues with per-port status flags and port B bus sizing.
// Assumes port clocks are plain inputs, far slower than ref_clk, sampled as synchronous.
`timescale 1ns/1ns
module dfs_flag_sync
    import dfs_pkg::*;
(
    // System
    input wire logic ref_clk,
    input wire logic rst,
    // Port clocks, sampled
    input wire logic port_a_clock,
    input wire logic port_b_clock,
    // Port A control and data
    input wire dfs_port_ctl_t port_a_ctl,
    input wire logic port_a_enable,
    input wire logic [DATA_W-1:0] port_a_data_in,
    output logic [DATA_W-1:0] port_a_data_out,
    // Port B control and data
    input wire dfs_port_ctl_t port_b_ctl,
    input wire logic port_b_enable,
    input wire logic bus_size_sel_lo,
    input wire logic bus_size_sel_hi,
    input wire logic [DATA_W-1:0] port_b_data_in,
    output logic [DATA_W-1:0] port_b_data_out,
    // Programmable offsets
    input wire logic [LVL_W-1:0] almost_empty_offset,
    input wire logic [LVL_W-1:0] almost_full_offset,
    // Port A flags
    output logic empty_flag_port_a,
    output logic almost_empty_port_a,
    output logic full_flag_port_a,
    output logic almost_full_port_a,
    // Port B flags
    output logic empty_flag_port_b,
    output logic almost_empty_port_b,
    output logic full_flag_port_b,
    output logic almost_full_port_b
);
    // ==========================================
    // Port clock edge enables
    logic a_clk_q_reg;
    logic b_clk_q_reg;
    wire logic a_edge = port_a_clock && !a_clk_q_reg;
    wire logic b_edge = port_b_clock && !b_clk_q_reg;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            a_clk_q_reg <= 1'b0;
            b_clk_q_reg <= 1'b0;
        end else begin
            a_clk_q_reg <= port_a_clock;
            b_clk_q_reg <= port_b_clock;
        end
    end

    // ==========================================
    // Access decode
    wire logic [1:0] b_size = {bus_size_sel_hi, bus_size_sel_lo};
    wire logic b_is_mail = (b_size == SIZ_MAIL); // R18
    wire logic a_fifo_sel = !port_a_ctl.select_n && !port_a_ctl.mailbox_sel && port_a_enable;
    wire logic b_fifo_sel = !port_b_ctl.select_n && !port_b_ctl.mailbox_sel && port_b_enable && !b_is_mail;
    wire logic a_wr_req = a_edge && a_fifo_sel && port_a_ctl.direction; // R14
    wire logic b_rd_req = b_edge && b_fifo_sel && !port_b_ctl.direction; // R14
    wire logic b_wr_req = b_edge && b_fifo_sel && port_b_ctl.direction; // R15
    wire logic a_rd_req = a_edge && a_fifo_sel && !port_a_ctl.direction; // R15

    // ==========================================
    // Port B piece sequencing
    logic [1:0] b_wr_idx_reg;
    logic [1:0] b_rd_idx_reg;
    logic [1:0] b_size_q_reg;
    logic [DATA_W-1:0] b_wr_buf_reg;
    wire logic [1:0] b_last_idx = (b_size == SIZ_WORD) ? LAST_WORD :
                                  (b_size == SIZ_BYTE) ? LAST_BYTE : LAST_LONG; // R13
    wire logic b_size_changed = (b_size != b_size_q_reg);
    // A size change restarts the long word at once, so an access on that edge is its first piece
    wire logic [1:0] b_wr_idx = b_size_changed ? 2'h0 : b_wr_idx_reg;
    wire logic [1:0] b_rd_idx = b_size_changed ? 2'h0 : b_rd_idx_reg;
    wire logic b_wr_last = (b_wr_idx == b_last_idx);
    wire logic b_rd_last = (b_rd_idx == b_last_idx);

    // A partial long word is dropped if the size code changes mid-way
    wire logic [DATA_W-1:0] b_word_pack = {b_wr_buf_reg[WORD_W-1:0], port_b_data_in[WORD_W-1:0]};
    wire logic [DATA_W-1:0] b_byte_pack = {b_wr_buf_reg[DATA_W-BYTE_W-1:0], port_b_data_in[BYTE_W-1:0]};
    wire logic [DATA_W-1:0] b_pack = (b_size == SIZ_WORD) ? b_word_pack :
                                     (b_size == SIZ_BYTE) ? b_byte_pack : port_b_data_in;

    // ==========================================
    // Queues
    logic ab_wr_ready;
    logic ab_rd_valid;
    logic [DATA_W-1:0] ab_rd_data;
    logic [LVL_W-1:0] ab_level;
    logic ba_wr_ready;
    logic ba_rd_valid;
    logic [DATA_W-1:0] ba_rd_data;
    logic [LVL_W-1:0] ba_level;

    // Writes to a full queue and reads of an empty one are ignored
    wire logic ab_push = a_wr_req && ab_wr_ready;
    wire logic ab_take = b_rd_req && ab_rd_valid;
    wire logic ab_pop = ab_take && b_rd_last; // R4 R8 R17
    wire logic ba_take = b_wr_req && ba_wr_ready;
    wire logic ba_push = ba_take && b_wr_last; // R2 R6 R10
    wire logic ba_pop = a_rd_req && ba_rd_valid;

    dfs_queue #(
        .WIDTH(DATA_W),
        .QDEPTH(DEPTH)
    ) u_a_to_b_queue (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_valid(ab_push),
        .wr_ready(ab_wr_ready),
        .wr_data(port_a_data_in),
        .rd_valid(ab_rd_valid),
        .rd_ready(ab_pop),
        .rd_data(ab_rd_data),
        .level(ab_level)
    );

    dfs_queue #(
        .WIDTH(DATA_W),
        .QDEPTH(DEPTH)
    ) u_b_to_a_queue (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_valid(ba_push),
        .wr_ready(ba_wr_ready),
        .wr_data(b_pack),
        .rd_valid(ba_rd_valid),
        .rd_ready(ba_pop),
        .rd_data(ba_rd_data),
        .level(ba_level)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            b_wr_idx_reg <= 2'h0;
            b_rd_idx_reg <= 2'h0;
        end else begin
            if (ba_take) begin
                b_wr_idx_reg <= b_wr_last ? 2'h0 : 2'(b_wr_idx + 1'b1);
            end else if (b_size_changed) begin
                b_wr_idx_reg <= 2'h0;
            end
            if (ab_take) begin
                b_rd_idx_reg <= b_rd_last ? 2'h0 : 2'(b_rd_idx + 1'b1);
            end else if (b_size_changed) begin
                b_rd_idx_reg <= 2'h0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            b_size_q_reg <= SIZ_LONG;
            b_wr_buf_reg <= DATA_RESET;
        end else begin
            b_size_q_reg <= b_size;
            if (ba_take && !b_wr_last) begin
                b_wr_buf_reg <= b_pack;
            end
        end
    end

    // ==========================================
    // Read data, big-endian piece order on port B
    wire logic [WORD_W-1:0] ab_word = (b_rd_idx == 2'h0) ? ab_rd_data[DATA_W-1:WORD_W] : ab_rd_data[WORD_W-1:0];
    wire logic [BYTE_W-1:0] ab_byte = ab_rd_data[(3 - b_rd_idx) * BYTE_W +: BYTE_W];
    // Unused lanes keep the previous output so narrow reads leave them stable
    wire logic [DATA_W-1:0] b_out_next = (b_size == SIZ_WORD) ? {port_b_data_out[DATA_W-1:WORD_W], ab_word} :
                                         (b_size == SIZ_BYTE) ? {port_b_data_out[DATA_W-1:BYTE_W], ab_byte} :
                                         ab_rd_data;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_a_data_out <= DATA_RESET;
            port_b_data_out <= DATA_RESET;
        end else begin
            if (ba_pop) begin
                port_a_data_out <= ba_rd_data;
            end
            if (ab_take) begin
                port_b_data_out <= b_out_next;
            end
        end
    end

    // ==========================================
    // Flags
    // Level after this ref_clk edge, so an own-port access shows at once
    wire logic [LVL_W-1:0] ab_level_next = LVL_W'(ab_level + LVL_W'(ab_push) - LVL_W'(ab_pop));
    wire logic [LVL_W-1:0] ba_level_next = LVL_W'(ba_level + LVL_W'(ba_push) - LVL_W'(ba_pop));
    wire logic [LVL_W-1:0] af_mark = LVL_W'(LVL_DEPTH - almost_full_offset);

    wire dfs_flags_t ab_flags_next = '{
        empty: (ab_level_next == '0),
        almost_empty: (ab_level_next <= almost_empty_offset),
        full: (ab_level_next == LVL_DEPTH),
        almost_full: (ab_level_next >= af_mark)
    };
    wire dfs_flags_t ba_flags_next = '{
        empty: (ba_level_next == '0),
        almost_empty: (ba_level_next <= almost_empty_offset),
        full: (ba_level_next == LVL_DEPTH),
        almost_full: (ba_level_next >= af_mark)
    };

    // Flags move only on their own port's edge; the far side's change is
    // picked up at the next such edge, never between port clocks
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            full_flag_port_a <= 1'b0;
            almost_full_port_a <= 1'b0;
            empty_flag_port_a <= 1'b1;
            almost_empty_port_a <= 1'b1;
        end else if (a_edge) begin
            full_flag_port_a <= ab_flags_next.full; // R3 R19
            almost_full_port_a <= ab_flags_next.almost_full; // R11 R19
            empty_flag_port_a <= ba_flags_next.empty; // R1 R20
            almost_empty_port_a <= ba_flags_next.almost_empty; // R9 R20
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            full_flag_port_b <= 1'b0;
            almost_full_port_b <= 1'b0;
            empty_flag_port_b <= 1'b1;
            almost_empty_port_b <= 1'b1;
        end else if (b_edge) begin
            full_flag_port_b <= ba_flags_next.full; // R5 R6 R19
            almost_full_port_b <= ba_flags_next.almost_full; // R12 R19
            empty_flag_port_b <= ab_flags_next.empty; // R17 R20
            almost_empty_port_b <= ab_flags_next.almost_empty; // R7 R8 R20
        end
    end
endmodule : dfs_flag_sync

// ==== verification/dfs_port_clocks.sv ====
// Partner model: the two port controllers' free-running port clocks.
// Assumes ref_clk is far faster than either port clock.
`timescale 1ns/1ns
module dfs_port_clocks #(
    parameter int HALF_A = 4,
    parameter int HALF_B = 6
) (
    // System
    input wire logic ref_clk,
    input wire logic rst,
    // Port clocks
    output logic port_a_clock,
    output logic port_b_clock
);
    int cnt_a_reg;
    int cnt_b_reg;
    // Periods of 8 and 12 ref_clk cycles so the ports drift past each other; low in reset avoids a false first edge
    always_ff @(posedge ref_clk) begin
        cnt_a_reg <= (rst || cnt_a_reg == 2 * HALF_A - 1) ? 0 : cnt_a_reg + 1;
        cnt_b_reg <= (rst || cnt_b_reg == 2 * HALF_B - 1) ? 0 : cnt_b_reg + 1;
    end
    assign port_a_clock = !rst && cnt_a_reg >= HALF_A;
    assign port_b_clock = !rst && cnt_b_reg >= HALF_B;
endmodule : dfs_port_clocks

// ==== verification/dfs_flag_sync_checker.sv ====
// Checker for the flag block, bound to its top module.
// Assumes flags are active high and a port edge is a low-to-high sample.
`timescale 1ns/1ns
module dfs_flag_sync_checker
    import dfs_pkg::*;
(
    // System and port clocks
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic port_a_clock,
    input wire logic port_b_clock,
    // Port controls
    input wire dfs_port_ctl_t port_a_ctl,
    input wire dfs_port_ctl_t port_b_ctl,
    input wire logic port_a_enable,
    input wire logic port_b_enable,
    input wire logic bus_size_sel_lo,
    input wire logic bus_size_sel_hi,
    // Flags
    input wire logic empty_flag_port_a,
    input wire logic almost_empty_port_a,
    input wire logic full_flag_port_a,
    input wire logic almost_full_port_a,
    input wire logic empty_flag_port_b,
    input wire logic almost_empty_port_b,
    input wire logic full_flag_port_b,
    input wire logic almost_full_port_b
);
    // ==========================================
    // Edge and access decode
    logic a_clk_reg;
    logic b_clk_reg;
    always_ff @(posedge ref_clk) begin
        a_clk_reg <= port_a_clock;
        b_clk_reg <= port_b_clock;
    end
    wire a_edge = port_a_clock & ~a_clk_reg;
    wire b_edge = port_b_clock & ~b_clk_reg;
    wire a_go = a_edge & ~port_a_ctl.select_n & port_a_enable & ~port_a_ctl.mailbox_sel;
    wire b_go = b_edge & ~port_b_ctl.select_n & port_b_enable & ~port_b_ctl.mailbox_sel
        & ~(bus_size_sel_hi & bus_size_sel_lo);
    wire a_rd = a_go & ~port_a_ctl.direction;
    wire a_wr = a_go & port_a_ctl.direction;
    wire b_rd = b_go & ~port_b_ctl.direction;
    wire b_wr = b_go & port_b_ctl.direction;
    wire [3:0] fa = {empty_flag_port_a, almost_empty_port_a, full_flag_port_a, almost_full_port_a};
    wire [3:0] fb = {empty_flag_port_b, almost_empty_port_b, full_flag_port_b, almost_full_port_b};

    // ==========================================
    // Assertions
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_reset_flags: assert property (disable iff (1'b0) rst |=> fa == 4'hc && fb == 4'hc)
        else $error("flags not at reset values");
    a_flags_a_steady: assert property (!a_edge |=> $stable(fa))
        else $error("port A flag moved off a port A edge");
    a_flags_b_steady: assert property (!b_edge |=> $stable(fb))
        else $error("port B flag moved off a port B edge");
    a_empty_a_nested: assert property (empty_flag_port_a |-> almost_empty_port_a)
        else $error("port A empty without almost empty");
    a_full_b_nested: assert property (full_flag_port_b |-> almost_full_port_b)
        else $error("port B full without almost full");
    a_empty_a_read: assert property ($rose(empty_flag_port_a) |-> $past(a_rd))
        else $error("port A empty set without a port A read");
    a_full_a_write: assert property ($rose(full_flag_port_a) |-> $past(a_wr))
        else $error("port A full set without a port A write");
    a_full_b_write: assert property ($rose(full_flag_port_b) |-> $past(b_wr))
        else $error("port B full set without a port B write");
    a_empty_b_read: assert property ($rose(empty_flag_port_b) |-> $past(b_rd))
        else $error("port B empty set without a port B read");
    a_aempty_b_read: assert property ($rose(almost_empty_port_b) |-> $past(b_rd))
        else $error("port B almost empty set without a port B read");
endmodule : dfs_flag_sync_checker

bind dfs_flag_sync dfs_flag_sync_checker dfs_flag_sync_checker_inst (.ref_clk, .rst, .port_a_clock, .port_b_clock,
    .port_a_ctl, .port_b_ctl, .port_a_enable, .port_b_enable, .bus_size_sel_lo, .bus_size_sel_hi,
    .empty_flag_port_a, .almost_empty_port_a, .full_flag_port_a, .almost_full_port_a,
    .empty_flag_port_b, .almost_empty_port_b, .full_flag_port_b, .almost_full_port_b);

// ==== verification/dfs_flag_sync_bench.sv ====
// Bench: port access tasks, queue level model, settled flag and data checks.
// Assumes the port clock model drives both port clocks.
`timescale 1ns/1ns
module dfs_flag_sync_bench import dfs_pkg::*;;
    logic ref_clk = 0;
    logic rst = 1;
    logic port_a_clock, port_b_clock, a_q = 0, b_q = 0;
    dfs_port_ctl_t port_a_ctl = 4'h8, port_b_ctl = 4'h8;
    logic port_a_enable = 0, port_b_enable = 0, bus_size_sel_lo = 0, bus_size_sel_hi = 0;
    logic [DATA_W-1:0] port_a_data_in = '0, port_b_data_in = '0, port_a_data_out, port_b_data_out;
    logic [LVL_W-1:0] almost_empty_offset = 5'h02, almost_full_offset = 5'h02;
    logic empty_flag_port_a, almost_empty_port_a, full_flag_port_a, almost_full_port_a;
    logic empty_flag_port_b, almost_empty_port_b, full_flag_port_b, almost_full_port_b;
    int bad_count = 0, check_count = 0, cycles = 0, lvl_ab = 0, lvl_ba = 0;
    wire a_edge = port_a_clock & ~a_q;
    wire b_edge = port_b_clock & ~b_q;
    wire dfs_flags_t flags_a = {empty_flag_port_a, almost_empty_port_a, full_flag_port_a, almost_full_port_a};
    wire dfs_flags_t flags_b = {empty_flag_port_b, almost_empty_port_b, full_flag_port_b, almost_full_port_b};

    dfs_port_clocks dfs_port_clocks_inst (.ref_clk, .rst, .port_a_clock, .port_b_clock);
    dfs_flag_sync dfs_flag_sync_inst (.ref_clk, .rst, .port_a_clock, .port_b_clock, .port_a_ctl, .port_a_enable,
        .port_a_data_in, .port_a_data_out, .port_b_ctl, .port_b_enable, .bus_size_sel_lo, .bus_size_sel_hi,
        .port_b_data_in, .port_b_data_out, .almost_empty_offset, .almost_full_offset,
        .empty_flag_port_a, .almost_empty_port_a, .full_flag_port_a, .almost_full_port_a,
        .empty_flag_port_b, .almost_empty_port_b, .full_flag_port_b, .almost_full_port_b);

    // ==========================================
    // Clock, timeout, reporting
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        a_q <= port_a_clock;
        b_q <= port_b_clock;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task chk_flags(input dfs_flags_t got, input dfs_flags_t exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected flags at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_flags
    task chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_data
    function dfs_flags_t exp_f(int e, int f);
        return {e == 0, e <= 2, f == 16, f >= 14};
    endfunction : exp_f
    function logic [DATA_W-1:0] wd(int i);
        return {4{i[8:0]}} ^ 36'h1_2345_6789;
    endfunction : wd
    // Port A sees three own edges and port B two, so every flag has had time to follow the levels
    task settle;
        repeat (24) @(posedge ref_clk);
        chk_flags(flags_a, exp_f(lvl_ba, lvl_ab));
        chk_flags(flags_b, exp_f(lvl_ab, lvl_ba));
    endtask : settle

    // ==========================================
    // Port access
    task a_op(input logic wr, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        port_a_ctl <= {1'h0, wr, 2'h0};
        port_a_enable <= 1'b1;
        port_a_data_in <= d;
        do @(posedge ref_clk); while (a_edge !== 1'b1);
        port_a_ctl <= 4'h8;
        port_a_enable <= 1'b0;
        port_a_data_in <= ~d;
    endtask : a_op
    task b_op(input logic wr, input logic [1:0] siz, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        port_b_ctl <= {1'h0, wr, 2'h0};
        {bus_size_sel_hi, bus_size_sel_lo} <= siz;
        port_b_enable <= 1'b1;
        port_b_data_in <= d;
        do @(posedge ref_clk); while (b_edge !== 1'b1);
        port_b_ctl <= 4'h8;
        port_b_enable <= 1'b0;
        port_b_data_in <= ~d;
    endtask : b_op
    // Narrow sizes: flags are checked just before the final piece, when nothing may have moved yet
    task b_xfer(input logic wr, input logic [1:0] siz, input logic [DATA_W-1:0] d);
        int n;
        int w;
        logic [DATA_W-1:0] m;
        logic [DATA_W-1:0] p;
        n = (siz == SIZ_BYTE) ? 4 : (siz == SIZ_WORD) ? 2 : 1;
        w = DATA_W / n;
        m = {DATA_W{1'b1}} >> (DATA_W - w);
        for (int k = 0; k < n; k++) begin
            p = (d >> (DATA_W - w * (k + 1))) & m;
            if (k == n - 1 && n > 1) settle();
            b_op(wr, siz, p);
            if (!wr) begin
                @(posedge ref_clk);
                chk_data(port_b_data_out & m, p);
            end
        end
        if (wr && lvl_ba < 16) lvl_ba++;
        if (!wr && lvl_ab > 0) lvl_ab--;
        settle();
    endtask : b_xfer

    // ==========================================
    // Tests
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        settle();
        for (int i = 0; i < 17; i++) begin
            a_op(1'b1, wd(i));
            if (lvl_ab < 16) lvl_ab++;
            if (i > 12) settle();
        end
        $display("fill of A-to-B queue done");
        b_op(1'b0, SIZ_MAIL, '0);
        settle();
        b_xfer(1'b0, SIZ_WORD, wd(0));
        for (int i = 1; i < 15; i++) b_xfer(1'b0, SIZ_LONG, wd(i));
        b_xfer(1'b0, SIZ_BYTE, wd(15));
        $display("drain of A-to-B queue done");
        b_xfer(1'b1, SIZ_BYTE, wd(20));
        b_xfer(1'b1, SIZ_WORD, wd(21));
        for (int i = 22; i < 35; i++) b_xfer(1'b1, SIZ_LONG, wd(i));
        b_xfer(1'b1, SIZ_BYTE, wd(35));
        b_xfer(1'b1, SIZ_LONG, wd(36));
        $display("fill of B-to-A queue done");
        for (int i = 20; i < 36; i++) begin
            a_op(1'b0, '0);
            lvl_ba--;
            @(posedge ref_clk);
            chk_data(port_a_data_out, wd(i));
            if (i < 23 || i > 32) settle();
        end
        $display("drain of B-to-A queue done");
        tally_and_finish();
    end
endmodule : dfs_flag_sync_bench
